// ===== verilog/uart_fifo_core.v
// Sixteen-byte FIFO UART: host registers, baud generator, transmitter, receiver, modem lines
//
// Overview of operation
// - Divisor-access bit maps addresses 0 and 1 to the divisor bytes.
// - Holding write taken while room exists; empty flag set as data moves on.
// - Start edge confirmed by a low sample mid start bit.
// - FIFO mode receive interrupt while fill is at or above trigger.
// - Data ready while the receive FIFO holds a byte.
// - Masked interrupts leave all status visible in line and modem status.
// - Line status shows transmit FIFO empty, transmitter idle, FIFO error.
// - Baud generator divides the clock by the 16-bit divisor.
// - Enable bits gate the four sources; upper bits read zero.
// - Identity codes 0110, 1100, 0010, 0000 by falling priority.
// - Identity bit 0 reads 0 while an enabled source is pending.
// - Identity bits 5:4 read zero; bits 7:6 show FIFO mode.
// - Only the highest pending source is presented and acknowledged.
// - FIFO enable bit first; trigger level takes a second write.
// - Clear bits empty a FIFO and its count; shifters untouched.
// - Setting the DMA bit selects mode 1; zero keeps the mode.
// - Trigger code selects 1, 4, 8 or 14 bytes.
// - Word length code selects 5 to 8 data bits.
// - Stop select gives 1, 1.5 for 5-bit words, or 2 stop bits.
// - Parity enable, even select and forced parity for send and check.
// - Break bit holds the serial output low outside loopback.
// - Modem control bits 0 and 1 drive ready and request outputs low outside loopback.
// - Loopback holds output high and turns transmitter and modem lines inward.
// - Modem change bits set on input changes, ring on trailing edge, cleared by read.
// - FIFO error flag sets on an errored character and clears on status read.
`default_nettype none
`include "uart_fifo_defines.vh"
module uart_fifo_core #(
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  // Clock and reset
  input  wire       clk_sys,
  input  wire       reset_n,
  // Host register port
  input  wire       chipSelect,
  input  wire [2:0] regAddr,
  input  wire       readStrobe,
  input  wire       writeStrobe,
  input  wire [7:0] writeData,
  output reg  [7:0] readData,
  output reg        readDataEn,
  output reg        irqOut,
  // DMA signalling
  output reg        receiveDmaReady_n,
  output reg        transmitDmaReady_n,
  // Serial line and baud clock
  input  wire       serialIn,
  output reg        serialOut,
  output reg        baudOut_n,
  // Modem lines
  input  wire       clearToSend_n,
  input  wire       dataSetReady_n,
  input  wire       ringIndicate_n,
  input  wire       carrierDetect_n,
  output reg        dataTerminalReady_n,
  output reg        requestToSend_n,
  output reg        userOutputOne_n,
  output reg        userOutputTwo_n
);
  localparam [2:0]  ST_IDLE  = 3'h0;
  localparam [2:0]  ST_START = 3'h1;
  localparam [2:0]  ST_DATA  = 3'h2;
  localparam [2:0]  ST_PAR   = 3'h3;
  localparam [2:0]  ST_STOP  = 3'h4;
  localparam [AW:0] CNT_ZERO = 0;
  localparam [AW:0] CNT_ONE  = 1;
  localparam [AW:0] CNT_FULL = DEPTH;

  reg  [7:0]    lineControl_r, scratchByte_r, txShift_r, rxShift_r, rdMux;
  reg  [4:0]    modemControl_r;
  reg  [3:0]    intEnable_r, rxTick_r, modemPrev_r, modemDelta_r, intId;
  reg  [15:0]   divisor_r, baudCnt_r;
  reg  [1:0]    trigSel_r;
  reg  [5:0]    txTick_r;
  reg  [2:0]    txState_r, txBit_r, rxState_r, rxBit_r;
  reg  [AW-1:0] txWp_r, txRp_r, rxWp_r, rxRp_r;
  reg  [AW:0]   txCnt_r, rxCnt_r;
  reg  [7:0]    txMem [0:DEPTH-1];
  reg  [10:0]   rxMem [0:DEPTH-1];
  reg           fifoEnable_r, dmaMode_r, rdPrev_r, wrPrev_r, txLine_r, txPar_r, rxPrev_r;
  reg           rxParSeen_r, overrun_r, fifoErr_r, thrPend_r, txEmptyPrev_r, modemPrimed_r;

  // Parity for the active word length and parity mode
  function parityOf;
    input [7:0] d;
    input [7:0] lc;
    reg   [7:0] masked;
    begin
      masked = d & (8'hFF >> (2'h3 - lc[1:0]));
      if (lc[`LC_STICK])
        parityOf = ~lc[`LC_EVEN];
      else
        parityOf = lc[`LC_EVEN] ? ^masked : ~^masked;
    end
  endfunction

  // Fill count update shared by both FIFOs
  function [AW:0] nextCount;
    input [AW:0] cnt;
    input        push;
    input        pop;
    input        clr;
    begin
      if (clr)
        nextCount = CNT_ZERO;
      else
        nextCount = cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  endfunction

  // Host strobes act once, on their first cycle
  wire          rdAct    = chipSelect & readStrobe & ~rdPrev_r;
  wire          wrAct    = chipSelect & writeStrobe & ~wrPrev_r;
  wire          divAcc   = lineControl_r[`LC_DIV_ACCESS];
  wire          loopOn   = modemControl_r[`MC_LOOP];
  wire          selData  = (regAddr == `OFS_DATA);
  wire          selIntEn = (regAddr == `OFS_INT_EN);
  wire          wrFifo   = wrAct & (regAddr == `OFS_INT_ID);
  wire          rdIntId  = rdAct & (regAddr == `OFS_INT_ID);
  wire          rdLine   = rdAct & (regAddr == `OFS_LINE_STAT);
  wire          rdModem  = rdAct & (regAddr == `OFS_MODEM_STA);
  wire [AW:0]   capacity = fifoEnable_r ? CNT_FULL : CNT_ONE;
  wire [2:0]    lastBit  = {1'b1, lineControl_r[1:0]};
  wire          parEn    = lineControl_r[`LC_PAR_EN];
  // Enable change flushes too, so stale bytes never cross a mode switch
  wire          fifoFlip = wrFifo & (writeData[`FC_ENABLE] != fifoEnable_r);
  wire          rxClear  = fifoFlip | (wrFifo & writeData[`FC_RX_CLEAR]);
  wire          txClear  = fifoFlip | (wrFifo & writeData[`FC_TX_CLEAR]);
  wire          txPush   = wrAct & selData & ~divAcc & (txCnt_r != capacity);
  wire          txPop    = (txState_r == ST_IDLE) & (txCnt_r != CNT_ZERO) & ~txClear;
  wire          tick     = (baudCnt_r == 16'h0000);
  wire          rxSrc    = loopOn ? txLine_r : serialIn;
  wire          rxDone   = (rxState_r == ST_STOP) & tick & (rxTick_r == `RX_BIT_END);
  wire [7:0]    rxData   = rxShift_r >> (3'h7 - lastBit);
  wire          rxParErr = parEn & (rxParSeen_r != parityOf(rxData, lineControl_r));
  wire          rxBreak  = ~rxSrc & (rxData == 8'h00) & (~parEn | ~rxParSeen_r);
  wire [10:0]   rxWord   = {rxBreak, ~rxSrc, rxParErr, rxData};
  wire          rxFull   = (rxCnt_r == capacity);
  wire          rxPush   = rxDone & ~rxFull & ~rxClear;
  wire          rxPop    = rdAct & selData & ~divAcc & (rxCnt_r != CNT_ZERO) & ~rxClear;
  wire          rxAny    = (rxCnt_r != CNT_ZERO);
  wire [10:0]   rxHead   = rxAny ? rxMem[rxRp_r] : 11'h000;
  wire          txFifoMt = (txCnt_r == CNT_ZERO);
  wire          txAllMt  = txFifoMt & (txState_r == ST_IDLE);
  wire [4:0]    trigLvl  = (trigSel_r == 2'h0) ? `TRIG_LVL0 :
                           (trigSel_r == 2'h1) ? `TRIG_LVL1 :
                           (trigSel_r == 2'h2) ? `TRIG_LVL2 : `TRIG_LVL3;
  wire          rxAtTrig = fifoEnable_r ? (rxCnt_r >= trigLvl) : rxAny;
  wire [3:0]    modemNow = loopOn ? {modemControl_r[3], modemControl_r[2],
                                     modemControl_r[0], modemControl_r[1]} :
                           {~carrierDetect_n, ~ringIndicate_n,
                            ~dataSetReady_n, ~clearToSend_n};
  wire          lineSrc  = overrun_r | (|rxHead[10:8]);
  wire [3:0]    pending  = intEnable_r & {|modemDelta_r, lineSrc, thrPend_r, rxAtTrig};
  wire [5:0]    stopLen  = ~lineControl_r[`LC_STOP2] ? `TX_BIT_TICKS :
                           (lineControl_r[1:0] == 2'h0) ? `TX_STOP15 : `TX_STOP2;
  wire [5:0]    txEnd    = ((txState_r == ST_STOP) ? stopLen : `TX_BIT_TICKS) - 6'h01;

  // Priority encoder; lower sources wait behind the presented one
  always @* begin
    if (pending[2])
      intId = `IID_LINE;
    else if (pending[0])
      intId = `IID_RX_DATA;
    else if (pending[1])
      intId = `IID_TX_EMPTY;
    else if (pending[3])
      intId = `IID_MODEM;
    else
      intId = `IID_NONE;
  end

  // Read multiplexer
  always @* begin
    case (regAddr)
      `OFS_DATA:      rdMux = divAcc ? divisor_r[7:0] : rxHead[7:0];
      `OFS_INT_EN:    rdMux = divAcc ? divisor_r[15:8] : {4'h0, intEnable_r};
      `OFS_INT_ID:    rdMux = {fifoEnable_r, fifoEnable_r, 2'h0, intId};
      `OFS_LINE_CTRL: rdMux = lineControl_r;
      `OFS_MODEM_CTL: rdMux = {3'h0, modemControl_r};
      `OFS_LINE_STAT: rdMux = {fifoErr_r & fifoEnable_r, txAllMt, txFifoMt,
                               rxHead[10:8], overrun_r, rxAny};
      `OFS_MODEM_STA: rdMux = {modemNow, modemDelta_r};
      default:        rdMux = scratchByte_r;
    endcase
  end

  // Host-written control state
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      lineControl_r  <= `LINE_CTRL_RST;
      modemControl_r <= `MODEM_CTL_RST;
      intEnable_r    <= `INT_EN_RST;
      scratchByte_r  <= 8'h00;
      divisor_r      <= `DIVISOR_RST;
      fifoEnable_r   <= 1'b0;
      dmaMode_r      <= 1'b0;
      trigSel_r      <= 2'h0;
      rdPrev_r       <= 1'b0;
      wrPrev_r       <= 1'b0;
      readData       <= 8'h00;
      readDataEn     <= 1'b0;
    end else begin
      rdPrev_r   <= chipSelect & readStrobe;
      wrPrev_r   <= chipSelect & writeStrobe;
      readDataEn <= chipSelect & readStrobe;
      if (rdAct)
        readData <= rdMux;
      if (wrAct) begin
        case (regAddr)
          `OFS_DATA:      if (divAcc) divisor_r[7:0] <= writeData;
          `OFS_INT_EN:    if (divAcc) divisor_r[15:8] <= writeData;
                          else intEnable_r <= writeData[3:0];
          `OFS_LINE_CTRL: lineControl_r <= writeData;
          `OFS_MODEM_CTL: modemControl_r <= writeData[4:0];
          `OFS_SCRATCH:   scratchByte_r <= writeData;
          default: ;
        endcase
      end
      if (wrFifo) begin
        fifoEnable_r <= writeData[`FC_ENABLE];
        // Trigger only lands once FIFOs were already on
        if (fifoEnable_r & writeData[`FC_ENABLE])
          trigSel_r <= writeData[7:6];
        if (writeData[`FC_DMA_MODE])
          dmaMode_r <= 1'b1;
      end
    end
  end

  // Baud divider, one 16x tick per divisor cycles
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      baudCnt_r <= 16'h0000;
      baudOut_n <= 1'b1;
    end else begin
      if (tick)
        baudCnt_r <= (divisor_r > 16'h0001) ? divisor_r - 16'h0001 : 16'h0000;
      else
        baudCnt_r <= baudCnt_r - 16'h0001;
      baudOut_n <= ~tick;
    end
  end

  // FIFO storage; arrays carry no reset
  always @(posedge clk_sys) begin
    if (txPush)
      txMem[txWp_r] <= writeData;
    if (rxPush)
      rxMem[rxWp_r] <= rxWord;
  end

  // FIFO pointers and fill counts
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      txWp_r  <= {AW{1'b0}};
      txRp_r  <= {AW{1'b0}};
      txCnt_r <= CNT_ZERO;
      rxWp_r  <= {AW{1'b0}};
      rxRp_r  <= {AW{1'b0}};
      rxCnt_r <= CNT_ZERO;
    end else begin
      txCnt_r <= nextCount(txCnt_r, txPush & ~txClear, txPop, txClear);
      rxCnt_r <= nextCount(rxCnt_r, rxPush, rxPop, rxClear);
      if (txClear) begin
        txWp_r <= {AW{1'b0}};
        txRp_r <= {AW{1'b0}};
      end else begin
        if (txPush)
          txWp_r <= txWp_r + 1'b1;
        if (txPop)
          txRp_r <= txRp_r + 1'b1;
      end
      if (rxClear) begin
        rxWp_r <= {AW{1'b0}};
        rxRp_r <= {AW{1'b0}};
      end else begin
        if (rxPush)
          rxWp_r <= rxWp_r + 1'b1;
        if (rxPop)
          rxRp_r <= rxRp_r + 1'b1;
      end
    end
  end

  // Transmit shifter
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      txState_r <= ST_IDLE;
      txShift_r <= 8'h00;
      txBit_r   <= 3'h0;
      txTick_r  <= 6'h00;
      txLine_r  <= 1'b1;
      txPar_r   <= 1'b0;
    end else if (txState_r == ST_IDLE) begin
      txLine_r <= 1'b1;
      txTick_r <= 6'h00;
      if (txPop) begin
        txShift_r <= txMem[txRp_r];
        txPar_r   <= parityOf(txMem[txRp_r], lineControl_r);
        txLine_r  <= 1'b0;
        txState_r <= ST_START;
      end
    end else if (tick) begin
      if (txTick_r != txEnd)
        txTick_r <= txTick_r + 6'h01;
      else begin
        txTick_r <= 6'h00;
        case (txState_r)
          ST_START: begin
            txState_r <= ST_DATA;
            txLine_r  <= txShift_r[0];
            txBit_r   <= 3'h0;
          end
          ST_DATA: begin
            if (txBit_r == lastBit) begin
              txState_r <= parEn ? ST_PAR : ST_STOP;
              txLine_r  <= parEn ? txPar_r : 1'b1;
            end else begin
              txShift_r <= txShift_r >> 1;
              txLine_r  <= txShift_r[1];
              txBit_r   <= txBit_r + 3'h1;
            end
          end
          ST_PAR: begin
            txState_r <= ST_STOP;
            txLine_r  <= 1'b1;
          end
          default: txState_r <= ST_IDLE;
        endcase
      end
    end
  end

  // Receive shifter, sampling mid-bit on 16x ticks
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rxState_r   <= ST_IDLE;
      rxShift_r   <= 8'h00;
      rxBit_r     <= 3'h0;
      rxTick_r    <= 4'h0;
      rxPrev_r    <= 1'b1;
      rxParSeen_r <= 1'b0;
    end else begin
      rxPrev_r <= rxSrc;
      case (rxState_r)
        ST_IDLE: begin
          rxTick_r <= 4'h0;
          if (rxPrev_r & ~rxSrc)
            rxState_r <= ST_START;
        end
        ST_START: if (tick) begin
          if (rxTick_r == `RX_START_MID) begin
            // A spike that has gone high again is dropped
            rxState_r <= rxSrc ? ST_IDLE : ST_DATA;
            rxTick_r  <= 4'h0;
            rxBit_r   <= 3'h0;
          end else
            rxTick_r <= rxTick_r + 4'h1;
        end
        default: if (tick) begin
          rxTick_r <= rxTick_r + 4'h1;
          if (rxTick_r == `RX_BIT_END) begin
            if (rxState_r == ST_DATA) begin
              rxShift_r <= {rxSrc, rxShift_r[7:1]};
              rxBit_r   <= rxBit_r + 3'h1;
              if (rxBit_r == lastBit)
                rxState_r <= parEn ? ST_PAR : ST_STOP;
            end else if (rxState_r == ST_PAR) begin
              rxParSeen_r <= rxSrc;
              rxState_r   <= ST_STOP;
            end else
              rxState_r <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // Sticky status; a new event wins over a clear in the same cycle
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      overrun_r     <= 1'b0;
      fifoErr_r     <= 1'b0;
      thrPend_r     <= 1'b0;
      txEmptyPrev_r <= 1'b1;
      modemPrev_r   <= 4'h0;
      modemPrimed_r <= 1'b0;
      modemDelta_r  <= 4'h0;
    end else begin
      if (rxDone & rxFull)
        overrun_r <= 1'b1;
      else if (rdLine)
        overrun_r <= 1'b0;
      if (rxPush & (|rxWord[10:8]))
        fifoErr_r <= 1'b1;
      else if (rdLine)
        fifoErr_r <= 1'b0;
      txEmptyPrev_r <= txFifoMt;
      if (txFifoMt & ~txEmptyPrev_r)
        thrPend_r <= 1'b1;
      else if (txPush | (rdIntId & (intId == `IID_TX_EMPTY)))
        thrPend_r <= 1'b0;
      modemPrev_r   <= modemNow;
      modemPrimed_r <= 1'b1;
      // First cycle out of reset has no history to compare
      if (modemPrimed_r)
        modemDelta_r <= (rdModem ? 4'h0 : modemDelta_r) |
                        {modemNow[3] ^ modemPrev_r[3], modemPrev_r[2] & ~modemNow[2],
                         modemNow[1] ^ modemPrev_r[1], modemNow[0] ^ modemPrev_r[0]};
      else if (rdModem)
        modemDelta_r <= 4'h0;
    end
  end

  // Registered pins
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      serialOut           <= 1'b1;
      irqOut              <= 1'b0;
      receiveDmaReady_n   <= 1'b1;
      transmitDmaReady_n  <= 1'b1;
      dataTerminalReady_n <= 1'b1;
      requestToSend_n     <= 1'b1;
      userOutputOne_n     <= 1'b1;
      userOutputTwo_n     <= 1'b1;
    end else begin
      serialOut <= loopOn | (~lineControl_r[`LC_BREAK] & txLine_r);
      irqOut    <= |pending;
      receiveDmaReady_n  <= ~((dmaMode_r & fifoEnable_r) ? rxAtTrig : rxAny);
      transmitDmaReady_n <= ~((dmaMode_r & fifoEnable_r) ? (txCnt_r != capacity) : txFifoMt);
      // Outputs held inactive in loopback; their values are turned inward
      dataTerminalReady_n <= loopOn | ~modemControl_r[0];
      requestToSend_n     <= loopOn | ~modemControl_r[1];
      userOutputOne_n     <= loopOn | ~modemControl_r[2];
      userOutputTwo_n     <= loopOn | ~modemControl_r[3];
    end
  end
endmodule
`default_nettype wire

// ===== verilog/uart_fifo_defines.vh
// Register offsets, field positions, reset values and bit timing for the FIFO UART
`ifndef UART_FIFO_DEFINES_VH
`define UART_FIFO_DEFINES_VH
// Register offsets on the 3-bit address
`define OFS_DATA      3'h0
`define OFS_INT_EN    3'h1
`define OFS_INT_ID    3'h2
`define OFS_LINE_CTRL 3'h3
`define OFS_MODEM_CTL 3'h4
`define OFS_LINE_STAT 3'h5
`define OFS_MODEM_STA 3'h6
`define OFS_SCRATCH   3'h7
// Line control fields
`define LC_DIV_ACCESS 7
`define LC_BREAK      6
`define LC_STICK      5
`define LC_EVEN       4
`define LC_PAR_EN     3
`define LC_STOP2      2
// Modem control and FIFO control fields
`define MC_LOOP       4
`define FC_ENABLE     0
`define FC_RX_CLEAR   1
`define FC_TX_CLEAR   2
`define FC_DMA_MODE   3
// Interrupt identity codes, bit 0 set means nothing pending
`define IID_LINE      4'h6
`define IID_RX_DATA   4'hC
`define IID_TX_EMPTY  4'h2
`define IID_MODEM     4'h0
`define IID_NONE      4'h1
// Receive trigger levels in bytes
`define TRIG_LVL0     5'h01
`define TRIG_LVL1     5'h04
`define TRIG_LVL2     5'h08
`define TRIG_LVL3     5'h0E
// Bit timing in 16x ticks
`define RX_START_MID  4'h7
`define RX_BIT_END    4'hF
`define TX_BIT_TICKS  6'h10
`define TX_STOP15     6'h18
`define TX_STOP2      6'h20
// Reset values
`define LINE_CTRL_RST 8'h00
`define MODEM_CTL_RST 5'h00
`define INT_EN_RST    4'h0
`define DIVISOR_RST   16'h0000
`endif

// ===== bench/uart_fifo_properties.sv
// Concurrent checks on the FIFO UART host port, serial output, baud clock and modem outputs
`default_nettype none
module uart_fifo_checker (
  // Clock and reset
  input wire logic       clk_sys,
  input wire logic       reset_n,
  // Host port
  input wire logic       chipSelect,
  input wire logic [2:0] regAddr,
  input wire logic       readStrobe,
  input wire logic       writeStrobe,
  input wire logic [7:0] writeData,
  input wire logic [7:0] readData,
  input wire logic       readDataEn,
  input wire logic       irqOut,
  // Line and modem outputs
  input wire logic       serialOut,
  input wire logic       baudOut_n,
  input wire logic       dataTerminalReady_n,
  input wire logic       requestToSend_n
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);
  logic        rdPrev_r, wrPrev_r, fifoOn_r;
  logic [7:0]  lc_r;
  logic [4:0]  mc_r;
  logic [3:0]  ie_r;
  logic [15:0] div_r, gap_r;
  logic [17:0] age_r;
  wire         rdTake = chipSelect && readStrobe && !rdPrev_r;
  wire         wrTake = chipSelect && writeStrobe && !wrPrev_r;
  // Shadow of writable controls; only the first cycle of a strobe counts
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      {rdPrev_r, wrPrev_r, fifoOn_r, lc_r, mc_r, ie_r, div_r, gap_r, age_r} <= '0;
    end else begin
      rdPrev_r <= chipSelect && readStrobe;
      wrPrev_r <= chipSelect && writeStrobe;
      gap_r <= baudOut_n ? gap_r + 16'h0001 : 16'h0001; // Cycles since last tick
      age_r <= (age_r == 18'h3FFFF) ? age_r : age_r + 18'h00001;
      if (wrTake) begin
        case (regAddr)
          3'h0: if (lc_r[7]) begin
            div_r[7:0] <= writeData;
            age_r <= 18'h00000;
          end
          3'h1: if (lc_r[7]) begin
            div_r[15:8] <= writeData;
            age_r <= 18'h00000;
          end else ie_r <= writeData[3:0];
          3'h2: fifoOn_r <= writeData[0];
          3'h3: lc_r <= writeData;
          3'h4: mc_r <= writeData[4:0];
          default: ;
        endcase
      end
    end
  end
  property p_rd_en; 1'b1 |=> readDataEn == $past(chipSelect && readStrobe); endproperty
  a_rd_en: assert property (p_rd_en) else $error("read enable does not follow strobe");
  property p_div_rd; rdTake && regAddr == 3'h0 && lc_r[7] |=> readData == div_r[7:0]; endproperty
  a_div_rd: assert property (p_div_rd) else $error("divisor low byte read wrong");
  property p_ier_rd; rdTake && regAddr == 3'h1 && !lc_r[7] |=> readData == {4'h0, ie_r}; endproperty
  a_ier_rd: assert property (p_ier_rd) else $error("interrupt enable read wrong");
  property p_id_rd; rdTake && regAddr == 3'h2 |=> readData[5:4] == 2'b00 && readData[7:6] == {2{fifoOn_r}};
  endproperty
  a_id_rd: assert property (p_id_rd) else $error("identity upper bits wrong");
  property p_irq_off; ie_r == 4'h0 && $past(ie_r) == 4'h0 |-> !irqOut; endproperty
  a_irq_off: assert property (p_irq_off) else $error("interrupt with all sources masked");
  property p_brk; lc_r[6] && $past(lc_r[6]) && !mc_r[4] && !$past(mc_r[4]) |-> !serialOut; endproperty
  a_brk: assert property (p_brk) else $error("break not held low");
  property p_loop; mc_r[4] && $past(mc_r[4]) |-> serialOut && dataTerminalReady_n && requestToSend_n;
  endproperty
  a_loop: assert property (p_loop) else $error("loopback outputs not high");
  property p_modem;
    !mc_r[4] && $stable(mc_r) |-> dataTerminalReady_n == !mc_r[0] && requestToSend_n == !mc_r[1];
  endproperty
  a_modem: assert property (p_modem) else $error("modem outputs wrong");
  property p_baud; !baudOut_n && div_r > 16'h0001 && age_r > {1'b0, div_r, 1'b0} |-> gap_r == div_r;
  endproperty
  a_baud: assert property (p_baud) else $error("baud tick spacing wrong");
  property p_baud_fast; div_r < 16'h0002 && age_r > 18'h00002 |-> !baudOut_n; endproperty
  a_baud_fast: assert property (p_baud_fast) else $error("baud tick missing");
  c_brk: cover property (lc_r[6] && !serialOut);
  c_loop: cover property (mc_r[4] && serialOut);
  c_irq: cover property ($rose(irqOut));
endmodule
bind uart_fifo_core uart_fifo_checker i_uart_fifo_checker (.clk_sys, .reset_n, .chipSelect, .regAddr,
  .readStrobe, .writeStrobe, .writeData, .readData, .readDataEn, .irqOut, .serialOut, .baudOut_n,
  .dataTerminalReady_n, .requestToSend_n);
`default_nettype wire

// ===== bench/serial_line_model.sv
// Serial line partner: sends frames into the receiver and captures transmitted frames
`default_nettype none
module serial_line_model #(
  parameter int DIV = 2
) (
  // Clock
  input  wire logic clk_sys,
  // Serial pair
  input  wire logic serialOut,
  output var  logic serialIn
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BITLEN = 16 * DIV;
  initial serialIn = 1'b1; // Line idles at mark
  // Hold a level for whole clocks, moving just after the edge
  task automatic hold(input logic v, input int n);
    serialIn = v;
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // Start, eight data bits LSB first, parity, stop
  task automatic sendByte(input logic [7:0] d, input logic p);
    @(posedge clk_sys);
    #1;
    hold(1'b0, BITLEN);
    for (int i = 0; i < 8; i++) hold(d[i], BITLEN);
    hold(p, BITLEN);
    hold(1'b1, BITLEN);
  endtask
  // Quarter-bit low spike
  task automatic glitch();
    @(posedge clk_sys);
    #1;
    hold(1'b0, 4 * DIV);
    serialIn = 1'b1;
  endtask
  // Sample each bit at its middle
  task automatic recvByte(output logic [7:0] d, output logic p);
    @(negedge serialOut);
    repeat (BITLEN / 2) @(posedge clk_sys);
    for (int i = 0; i < 9; i++) begin
      repeat (BITLEN) @(posedge clk_sys);
      if (i < 8) d[i] = serialOut;
      else p = serialOut;
    end
  endtask
endmodule
`default_nettype wire

// ===== bench/fifo_uart_16byte_tb.sv
// Self-checking bench for the FIFO UART: registers, framing, receive FIFO, modem and break outputs
`default_nettype none
module fifo_uart_16byte_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk_sys = 1'b0, reset_n = 1'b0;
  logic       chipSelect = 1'b0, readStrobe = 1'b0, writeStrobe = 1'b0;
  logic [2:0] regAddr = 3'h0;
  logic [7:0] writeData = 8'h00, readData;
  logic       readDataEn, irqOut, receiveDmaReady_n, transmitDmaReady_n, serialIn, serialOut, baudOut_n;
  logic       clearToSend_n = 1'b1, dataSetReady_n = 1'b1, ringIndicate_n = 1'b1, carrierDetect_n = 1'b1;
  logic       dataTerminalReady_n, requestToSend_n, userOutputOne_n, userOutputTwo_n;
  int         mismatches = 0, checks_done = 0, cycles = 0;
  always #50 clk_sys = ~clk_sys;
  uart_fifo_core i_uart_fifo_core (.clk_sys, .reset_n, .chipSelect, .regAddr, .readStrobe, .writeStrobe,
    .writeData, .readData, .readDataEn, .irqOut, .receiveDmaReady_n, .transmitDmaReady_n, .serialIn, .serialOut,
    .baudOut_n, .clearToSend_n, .dataSetReady_n, .ringIndicate_n, .carrierDetect_n, .dataTerminalReady_n,
    .requestToSend_n, .userOutputOne_n, .userOutputTwo_n);
  serial_line_model #(.DIV(2)) i_serial_line_model (.clk_sys, .serialOut, .serialIn);
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // One taken edge per access
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    wt(1);
    {chipSelect, writeStrobe, regAddr, writeData} = {2'b11, a, d};
    wt(1);
    {chipSelect, writeStrobe} = 2'b00;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    wt(1);
    {chipSelect, readStrobe, regAddr} = {2'b11, a};
    wt(1);
    {chipSelect, readStrobe} = 2'b00;
    d = readData;
  endtask
  task automatic t_regs();
    logic [7:0] v;
    rd(3'h2, v);
    chk(v, 8'h01);
    rd(3'h5, v);
    chk(v, 8'h60);
    wr(3'h1, 8'hFF);
    rd(3'h1, v);
    chk(v, 8'h0F);
    wr(3'h3, 8'h80);
    wr(3'h0, 8'h02);
    wr(3'h1, 8'h00);
    rd(3'h0, v);
    chk(v, 8'h02);
    wr(3'h3, 8'h1B);
    rd(3'h1, v);
    chk(v, 8'h0F);
    wr(3'h1, 8'h00);
    $display("register test done");
  endtask
  task automatic t_tx();
    logic [7:0] d, v;
    logic       p;
    fork
      i_serial_line_model.recvByte(d, p);
      begin
        wr(3'h0, 8'h35);
        rd(3'h5, v);
        chk({7'h0, v[6]}, 8'h00);
      end
    join
    chk(d, 8'h35);
    chk({7'h0, p}, {7'h0, ^8'h35});
    wt(80);
    rd(3'h5, v);
    chk(v, 8'h60);
    chk({7'h0, transmitDmaReady_n}, 8'h00);
    $display("transmit test done");
  endtask
  task automatic t_rx();
    logic [7:0] v;
    wr(3'h2, 8'h01);
    wr(3'h2, 8'h49); // Second step sets trigger and receive DMA mode
    wr(3'h1, 8'h01);
    for (int i = 0; i < 3; i++) i_serial_line_model.sendByte(8'h50 + 8'(i), ^(8'h50 + 8'(i)));
    wt(2);
    rd(3'h2, v);
    chk(v, 8'hC1);
    chk({7'h0, receiveDmaReady_n}, 8'h01);
    i_serial_line_model.sendByte(8'h53, ^8'h53);
    wt(3);
    chk({7'h0, irqOut}, 8'h01);
    chk({7'h0, receiveDmaReady_n}, 8'h00);
    rd(3'h2, v);
    chk(v, 8'hCC);
    rd(3'h5, v);
    chk(v, 8'h61);
    rd(3'h0, v);
    chk(v, 8'h50);
    wt(2);
    chk({7'h0, irqOut}, 8'h00);
    wr(3'h2, 8'h43);
    rd(3'h5, v);
    chk(v, 8'h60);
    wr(3'h1, 8'h00);
    i_serial_line_model.glitch();
    wt(400);
    rd(3'h5, v);
    chk(v, 8'h60);
    $display("receive test done");
  endtask
  task automatic t_lines();
    logic [7:0] v;
    clearToSend_n = 1'b0;
    rd(3'h6, v);
    chk(v, 8'h11);
    rd(3'h6, v);
    chk(v, 8'h10);
    wr(3'h4, 8'h0F);
    wt(2);
    chk({4'h0, dataTerminalReady_n, requestToSend_n, userOutputOne_n, userOutputTwo_n}, 8'h00);
    wr(3'h3, 8'h5B);
    wt(2);
    chk({7'h0, serialOut}, 8'h00);
    wr(3'h4, 8'h13);
    wt(2);
    chk({6'h0, dataTerminalReady_n, requestToSend_n, serialOut}, 8'h07);
    wr(3'h4, 8'h00);
    wr(3'h3, 8'h1B);
    wt(2);
    chk({6'h0, dataTerminalReady_n, serialOut}, 8'h03);
    $display("line output test done");
  endtask
  task automatic results();
    $display("Checks %0d, mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Hang guard, well above the test length
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 30000) begin
      mismatches++;
      $display("ERROR %0t: timeout", $time);
      results();
    end
  end
  initial begin
    wt(20);
    reset_n = 1'b1;
    t_regs();
    t_tx();
    t_rx();
    t_lines();
    results();
  end
endmodule
`default_nettype wire
